// ---- mp_uart_pkg.sv ----
/*
 * shared constants for the multi-processor address-filtering serial link:
 * register offsets, field positions, sampling figures and frame sizes.
 * assumes a single 125 MHz clock and synchronous active-high reset.
 */
//
// Contract
// - filter on: drop data frames silently
// - 5..8 bits: first stop is type
// - 9 bits: ninth data bit is type
// - type one address, zero data
// - transmitter ignores filter bit
// - accepted address stored, complete flag raised
// - master sets ninth bit for addresses
// - slaves use 9-bit format then
// - 5..8 bit sender uses two stops
// - one char size for both directions
// - filter bit shares transmit-complete register
// - 16 samples normal, 8 double
// - first vote sample 8 or 4
// - middle vote sample 9 or 5
// - support 5 to 9 bit frames
// - sender bit rate near receiver rate
// - majority vote of three centre samples
package mp_uart_pkg;
	// register offsets on the software port
	localparam logic [2:0] reg_ctrl_status_a = 3'h0;
	localparam logic [2:0] reg_config = 3'h1;
	localparam logic [2:0] reg_baud = 3'h2;
	localparam logic [2:0] reg_data = 3'h3;
	localparam logic [2:0] reg_irq_status = 3'h4;
	localparam logic [2:0] reg_irq_mask = 3'h5;
	// ctrl_status_reg_a fields
	localparam int bit_addr_filter = 0;
	localparam int bit_double_speed = 1;
	localparam int bit_tx_complete = 6;
	localparam int bit_rx_complete = 7;
	// config fields
	localparam int bit_two_stop = 3;
	localparam int pos_char_size = 0;
	localparam int bit_tx_ninth = 4;
	localparam int bit_rx_ninth = 5;
	// interrupt bits
	localparam int irq_rx = 0;
	localparam int irq_tx = 1;
	localparam int irq_width = 2;
	// char_size_field codes: 0..3 = 5..8 bits, 7 = 9 bits
	localparam logic [2:0] size_nine = 3'h7;
	localparam logic [3:0] size_base = 4'h5;
	localparam logic [3:0] size_max = 4'h9;
	// sampling: per-bit sample counts and vote positions
	localparam logic [3:0] samples_normal_last = 4'hf;
	localparam logic [3:0] samples_double_last = 4'h7;
	localparam logic [3:0] vote_first_normal = 4'h8;
	localparam logic [3:0] vote_mid_normal = 4'h9;
	localparam logic [3:0] vote_first_double = 4'h4;
	localparam logic [3:0] vote_mid_double = 4'h5;
	localparam logic [15:0] baud_reset = 16'h0000;
	localparam logic [7:0] reset_zero8 = 8'h00;
endpackage

// ---- mp_uart_if.sv ----
/*
 * serial link between two ends: one wire each way.
 * assumes both ends share clk_i; line idles high.
 */
`timescale 1ns/1ns
interface mp_uart_if (
	input wire logic clk_i
);
	logic line_a_to_b;
	logic line_b_to_a;
	modport dev (input clk_i, input line_b_to_a, output line_a_to_b);
	modport far (input clk_i, input line_a_to_b, output line_b_to_a);
endinterface

// ---- mp_uart_dev.sv ----
/*
 * serial receiver/transmitter with multi-processor address filtering,
 * software register port, sticky interrupts.
 * assumes the far end sends at a rate close to our baud setting.
 */
`timescale 1ns/1ns
module mp_uart_dev (
	input wire logic clk_i,
	input wire logic rst_i,
	mp_uart_if.dev link,
	input wire logic [2:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	output logic irq_o
);
	localparam int irq_width_c = mp_uart_pkg::irq_width;
	typedef enum logic [1:0] {idle, start, bits, stop} rx_state_t;
	typedef enum logic [1:0] {t_idle, t_start, t_bits, t_stop} tx_state_t;
	typedef struct packed {
		logic addr_filter_bit;
		logic double_speed_select;
		logic two_stop_select;
		logic [2:0] char_size_field;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic [15:0] baud;
		logic [15:0] baud_cnt;
		logic [1:0] rx_sync;
		rx_state_t rx_st;
		logic [3:0] rx_samp;
		logic [3:0] rx_idx;
		logic [8:0] rx_shift;
		logic [2:0] votes;
		logic [7:0] rx_tx_data_reg;
		logic [irq_width_c-1:0] irq_status;
		logic [irq_width_c-1:0] irq_mask;
		tx_state_t tx_st;
		logic [3:0] tx_samp;
		logic [3:0] tx_idx;
		logic [8:0] tx_shift;
		logic tx_line;
		logic stop2;
		logic [15:0] rdata;
	} state_t;
	state_t s, n;
	logic tick;
	logic [3:0] last_samp;
	logic [3:0] nbits;
	logic rx_in;

	// bit count from size code, shared by both directions
	function automatic logic [3:0] char_bits(input logic [2:0] code);
		if (code == mp_uart_pkg::size_nine) begin
			char_bits = mp_uart_pkg::size_max;
		end else begin
			char_bits = mp_uart_pkg::size_base + {2'h0, code[1:0]};
		end
	endfunction

	// majority of three
	function automatic logic vote(input logic [2:0] v);
		vote = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	always_comb begin
		// at or above, so a lowered divider never waits for a counter wrap
		tick = (s.baud_cnt >= s.baud);
		last_samp = s.double_speed_select ? mp_uart_pkg::samples_double_last
			: mp_uart_pkg::samples_normal_last;
		nbits = char_bits(s.char_size_field);
		rx_in = s.rx_sync[1];
		rdata_o = s.rdata;
		irq_o = |(s.irq_status & s.irq_mask);
		link.line_a_to_b = s.tx_line;
	end

	always_comb begin
		logic [3:0] first_v;
		logic [3:0] mid_v;
		logic bitv;
		logic ftype;
		logic [irq_width_c-1:0] set_ev;
		n = s;
		set_ev = '0;
		first_v = s.double_speed_select ? mp_uart_pkg::vote_first_double
			: mp_uart_pkg::vote_first_normal;
		mid_v = s.double_speed_select ? mp_uart_pkg::vote_mid_double
			: mp_uart_pkg::vote_mid_normal;
		bitv = vote(s.votes);
		ftype = 1'b0;
		n.rx_sync = {s.rx_sync[0], link.line_b_to_a};
		n.rdata = 16'h0000;
		n.baud_cnt = tick ? 16'h0000 : s.baud_cnt + 16'h0001;
		// rx_samp runs one behind the sample number (first low sample is 1),
		// so samples first_v, mid_v, mid_v+1 sit at rx_samp one lower
		if (tick) begin
			if (s.rx_samp + 4'h1 == first_v) n.votes[0] = rx_in;
			if (s.rx_samp + 4'h1 == mid_v) n.votes[1] = rx_in;
			if (s.rx_samp == mid_v) n.votes[2] = rx_in;
			case (s.rx_st)
				idle: begin
					n.rx_samp = 4'h1;
					if (!rx_in) n.rx_st = start;
				end
				start: begin
					n.rx_samp = s.rx_samp + 4'h1;
					if (s.rx_samp == last_samp) begin
						n.rx_samp = 4'h0;
						n.rx_idx = 4'h0;
						// short sizes must not carry bits of an earlier frame
						n.rx_shift = 9'h000;
						// noise spike rejected by the vote
						n.rx_st = bitv ? idle : bits;
					end
				end
				bits: begin
					n.rx_samp = s.rx_samp + 4'h1;
					if (s.rx_samp == last_samp) begin
						n.rx_samp = 4'h0;
						n.rx_shift[s.rx_idx] = bitv;
						n.rx_idx = s.rx_idx + 4'h1;
						if (s.rx_idx == nbits - 4'h1) n.rx_st = stop;
					end
				end
				stop: begin
					n.rx_samp = s.rx_samp + 4'h1;
					// decide right after the vote window, early restart allowed
					if (s.rx_samp == mid_v + 4'h1) begin
						n.rx_st = idle;
						ftype = (nbits == mp_uart_pkg::size_max)
							? s.rx_shift[8]
							: bitv;
						// one marks address, zero marks data; drop data when filtering
						if (!s.addr_filter_bit || ftype) begin
							n.rx_tx_data_reg = s.rx_shift[7:0];
							n.rx_ninth_bit = s.rx_shift[8];
							n.irq_status[mp_uart_pkg::irq_rx] = 1'b1;
							set_ev[mp_uart_pkg::irq_rx] = 1'b1;
						end
					end
				end
				default: n.rx_st = idle;
			endcase
		end
		// transmitter: never looks at the filter bit
		if (tick) begin
			n.tx_samp = s.tx_samp + 4'h1;
			if (s.tx_samp == last_samp) begin
				n.tx_samp = 4'h0;
				case (s.tx_st)
					t_start: begin
						n.tx_line = s.tx_shift[0];
						n.tx_idx = 4'h1;
						n.tx_st = t_bits;
					end
					t_bits: begin
						if (s.tx_idx == nbits) begin
							n.tx_line = 1'b1;
							n.stop2 = s.two_stop_select;
							n.tx_st = t_stop;
						end else begin
							n.tx_line = s.tx_shift[s.tx_idx];
							n.tx_idx = s.tx_idx + 4'h1;
						end
					end
					t_stop: begin
						n.stop2 = 1'b0;
						if (!s.stop2) begin
							n.tx_st = t_idle;
							n.irq_status[mp_uart_pkg::irq_tx] = 1'b1;
							set_ev[mp_uart_pkg::irq_tx] = 1'b1;
						end
					end
					default: n.tx_st = t_idle;
				endcase
			end
		end
		// software port; hardware set wins over write-one clear
		if (wr_i) begin
			case (addr_i)
				mp_uart_pkg::reg_ctrl_status_a: begin
					n.addr_filter_bit = wdata_i[mp_uart_pkg::bit_addr_filter];
					n.double_speed_select = wdata_i[mp_uart_pkg::bit_double_speed];
				end
				mp_uart_pkg::reg_config: begin
					n.char_size_field = wdata_i[mp_uart_pkg::pos_char_size +: 3];
					n.two_stop_select = wdata_i[mp_uart_pkg::bit_two_stop];
					n.tx_ninth_bit = wdata_i[mp_uart_pkg::bit_tx_ninth];
				end
				mp_uart_pkg::reg_baud: n.baud = wdata_i;
				mp_uart_pkg::reg_data: begin
					if (s.tx_st == t_idle) begin
						n.tx_shift = {s.tx_ninth_bit, wdata_i[7:0]};
						n.tx_st = t_start;
						n.tx_line = 1'b0;
						n.tx_samp = 4'h0;
					end
				end
				mp_uart_pkg::reg_irq_status:
					n.irq_status = (n.irq_status & ~wdata_i[irq_width_c-1:0]) | set_ev;
				mp_uart_pkg::reg_irq_mask: n.irq_mask = wdata_i[irq_width_c-1:0];
				default: ;
			endcase
		end
		if (rd_i) begin
			case (addr_i)
				mp_uart_pkg::reg_ctrl_status_a: begin
					// filter bit shares this word with transmit complete
					n.rdata[mp_uart_pkg::bit_addr_filter] = s.addr_filter_bit;
					n.rdata[mp_uart_pkg::bit_double_speed] = s.double_speed_select;
					n.rdata[mp_uart_pkg::bit_tx_complete] = s.irq_status[mp_uart_pkg::irq_tx];
					n.rdata[mp_uart_pkg::bit_rx_complete] = s.irq_status[mp_uart_pkg::irq_rx];
				end
				mp_uart_pkg::reg_config: begin
					n.rdata[mp_uart_pkg::pos_char_size +: 3] = s.char_size_field;
					n.rdata[mp_uart_pkg::bit_two_stop] = s.two_stop_select;
					n.rdata[mp_uart_pkg::bit_tx_ninth] = s.tx_ninth_bit;
					n.rdata[mp_uart_pkg::bit_rx_ninth] = s.rx_ninth_bit;
				end
				mp_uart_pkg::reg_baud: n.rdata = s.baud;
				mp_uart_pkg::reg_data: n.rdata = {8'h00, s.rx_tx_data_reg};
				mp_uart_pkg::reg_irq_status: n.rdata = {14'h0000, s.irq_status};
				mp_uart_pkg::reg_irq_mask: n.rdata = {14'h0000, s.irq_mask};
				default: n.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.rx_sync <= 2'h3;
			s.tx_line <= 1'b1;
			s.rx_st <= idle;
			s.tx_st <= t_idle;
			s.baud <= mp_uart_pkg::baud_reset;
		end else begin
			s <= n;
		end
	end
endmodule

// ---- mp_uart_far.sv ----
/*
 * far end: a master that sends address and data frames at a fixed
 * divided rate, 16 samples per bit, and returns nothing.
 * assumes the user holds send_i for one cycle while ready_o is high.
 */
`timescale 1ns/1ns
module mp_uart_far (
	input wire logic clk_i,
	input wire logic rst_i,
	mp_uart_if.far link,
	input wire logic [15:0] baud_i,
	input wire logic nine_bit_i,
	input wire logic [2:0] char_size_i,
	input wire logic send_i,
	input wire logic is_addr_i,
	input wire logic [7:0] data_i,
	output logic ready_o
);
	typedef struct packed {
		logic busy;
		logic [15:0] cnt;
		logic [3:0] samp;
		logic [3:0] idx;
		logic [3:0] len;
		logic [11:0] frame;
		logic line;
	} far_t;
	far_t s, n;

	always_comb begin
		ready_o = !s.busy;
		link.line_b_to_a = s.line;
	end

	// frame: start, data, then ninth bit or type-carrying stops
	always_comb begin
		n = s;
		n.cnt = (s.cnt >= baud_i) ? 16'h0000 : s.cnt + 16'h0001;
		if (send_i && !s.busy) begin
			n.busy = 1'b1;
			n.samp = 4'h0;
			n.idx = 4'h0;
			n.cnt = 16'h0000;
			if (nine_bit_i) begin
				n.frame = {2'h3, is_addr_i, data_i, 1'b0};
				n.len = 4'hb;
			end else begin
				// first stop carries type, second stop real
				n.frame = 12'h000;
				n.frame[0] = 1'b0;
				n.frame[8:1] = data_i;
				n.len = mp_uart_pkg::size_base + {2'h0, char_size_i[1:0]} + 4'h1;
				n.frame[n.len] = is_addr_i;
				n.frame[n.len + 4'h1] = 1'b1;
				n.len = n.len + 4'h2;
			end
			n.line = 1'b0;
		end else if (s.busy && s.cnt >= baud_i) begin
			n.samp = s.samp + 4'h1;
			if (s.samp == mp_uart_pkg::samples_normal_last) begin
				n.idx = s.idx + 4'h1;
				if (s.idx + 4'h1 == s.len) begin
					n.busy = 1'b0;
					n.line = 1'b1;
				end else begin
					n.line = s.frame[s.idx + 4'h1];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.line <= 1'b1;
		end else begin
			s <= n;
		end
	end
endmodule

// ---- mp_uart_link_assertions.sv ----
/*
 * checks on the two serial wires joining the far end and the device.
 * assumes one clock, synchronous active-high reset, lines idling high.
 */
`timescale 1ns/1ns
module mp_uart_link_assertions (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic line_a_to_b,
	input wire logic line_b_to_a
);
	logic [7:0] low_a;
	logic [7:0] low_b;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// low run lengths; a stuck-low line shows as a run beyond one frame
	always_ff @(posedge clk_i) begin
		if (rst_i || line_a_to_b) begin
			low_a <= 8'h00;
		end else if (low_a != 8'hff) begin
			low_a <= low_a + 8'h01;
		end
		if (rst_i || line_b_to_a) begin
			low_b <= 8'h00;
		end else if (low_b != 8'hff) begin
			low_b <= low_b + 8'h01;
		end
	end
	tx_idle_reset_a: assert property ($fell(rst_i) |-> line_a_to_b [*4])
		else $error("device line not idle after reset");
	far_idle_reset_a: assert property ($fell(rst_i) |-> line_b_to_a [*4])
		else $error("far line not idle after reset");
	tx_low_hold_a: assert property ($fell(line_a_to_b) |-> !line_a_to_b [*8])
		else $error("device low level shorter than a bit");
	tx_high_hold_a: assert property ($rose(line_a_to_b) |-> line_a_to_b [*8])
		else $error("device high level shorter than a bit");
	far_low_hold_a: assert property ($fell(line_b_to_a) |-> !line_b_to_a [*8])
		else $error("far low level shorter than a bit");
	far_high_hold_a: assert property ($rose(line_b_to_a) |-> line_b_to_a [*8])
		else $error("far high level shorter than a bit");
	tx_frame_bound_a: assert property (low_a < 8'hc8)
		else $error("device line low longer than a frame");
	far_frame_bound_a: assert property (low_b < 8'hc8)
		else $error("far line low longer than a frame");
	// main traffic seen on each wire
	cover property ($fell(line_b_to_a));
	cover property ($fell(line_a_to_b));
	cover property (low_b > 8'h40);
endmodule

// ---- uart_multiproc_address_filter_tb_top.sv ----
/*
 * testbench: device and far end joined by the link interface.
 * assumes 125 MHz clock; far end always at divider 0 (16 clocks a bit).
 */
`timescale 1ns/1ns
module uart_multiproc_address_filter_tb_top;
	localparam logic [2:0] a_ctl = mp_uart_pkg::reg_ctrl_status_a;
	localparam logic [2:0] a_cfg = mp_uart_pkg::reg_config;
	localparam logic [2:0] a_baud = mp_uart_pkg::reg_baud;
	localparam logic [2:0] a_dat = mp_uart_pkg::reg_data;
	localparam logic [2:0] a_irq = mp_uart_pkg::reg_irq_status;
	localparam logic [2:0] a_msk = mp_uart_pkg::reg_irq_mask;
	logic clk_i;
	logic rst_i;
	logic [2:0] addr_i;
	logic [15:0] wdata_i;
	logic [15:0] rdata;
	logic wr_i, rd_i, irq, nine, send_i, is_addr_i, ready;
	logic [2:0] csz;
	logic [7:0] data_i;
	int mismatches;
	int tests_run;

	mp_uart_if mp_uart_if_i (.clk_i(clk_i));
	mp_uart_dev mp_uart_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(mp_uart_if_i.dev),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
		.irq_o(irq));
	mp_uart_far mp_uart_far_i (.clk_i(clk_i), .rst_i(rst_i), .link(mp_uart_if_i.far),
		.baud_i(16'h0000), .nine_bit_i(nine), .char_size_i(csz), .send_i(send_i),
		.is_addr_i(is_addr_i), .data_i(data_i), .ready_o(ready));
	mp_uart_link_assertions mp_uart_link_assertions_i (.clk_i(clk_i), .rst_i(rst_i),
		.line_a_to_b(mp_uart_if_i.line_a_to_b), .line_b_to_a(mp_uart_if_i.line_b_to_a));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one-cycle strobes launched just after an edge
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input string what, input logic [2:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(what, exp, rdata & m);
	endtask
	// one frame from the far end; margin lets the device flag land
	task automatic send(input logic t, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		is_addr_i <= t;
		data_i <= d;
		send_i <= 1'b1;
		@(posedge clk_i);
		send_i <= 1'b0;
		#1;
		for (n = 0; n < 400 && ready !== 1'b1; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 400) begin
			mismatches++;
			summarize();
		end
		repeat (8) @(posedge clk_i);
	endtask
	task automatic t_regs();
		rd("ctrl reset", a_ctl, 16'hffff, 16'h0000);
		rd("baud reset", a_baud, 16'hffff, 16'h0000);
		rd("unmapped", 3'h6, 16'hffff, 16'h0000);
	endtask
	task automatic t_nine();
		wr(a_cfg, 16'h0007);
		wr(a_ctl, 16'h0001);
		wr(a_msk, 16'h0001);
		send(1'b0, 8'ha5);
		rd("data dropped", a_irq, 16'h0001, 16'h0000);
		chk("irq idle", 16'h0000, {15'h0000, irq});
		send(1'b1, 8'h12);
		rd("addr flag", a_irq, 16'h0001, 16'h0001);
		chk("irq raised", 16'h0001, {15'h0000, irq});
		rd("addr byte", a_dat, 16'h00ff, 16'h0012);
		rd("ninth set", a_cfg, 16'h0020, 16'h0020);
		wr(a_irq, 16'h0001);
		#1 chk("irq cleared", 16'h0000, {15'h0000, irq});
	endtask
	task automatic t_open();
		wr(a_ctl, 16'h0000);
		wr(a_msk, 16'h0000);
		send(1'b0, 8'h77);
		rd("open flag", a_irq, 16'h0001, 16'h0001);
		chk("irq masked", 16'h0000, {15'h0000, irq});
		rd("open byte", a_dat, 16'h00ff, 16'h0077);
		rd("ninth clear", a_cfg, 16'h0020, 16'h0000);
		wr(a_irq, 16'h0001);
	endtask
	// 8-bit frames: the type rides in the first stop bit
	task automatic t_eight();
		wr(a_cfg, 16'h000b);
		wr(a_ctl, 16'h0001);
		nine <= 1'b0;
		send(1'b0, 8'h55);
		rd("short drop", a_irq, 16'h0001, 16'h0000);
		send(1'b1, 8'h81);
		rd("short addr", a_dat, 16'h00ff, 16'h0081);
		wr(a_irq, 16'h0001);
		nine <= 1'b1;
	endtask
	// 8 samples a bit at divider 1 matches the far end's 16 clocks a bit
	task automatic t_double();
		wr(a_cfg, 16'h0007);
		wr(a_ctl, 16'h0002);
		wr(a_baud, 16'h0001);
		send(1'b0, 8'h3c);
		rd("double byte", a_dat, 16'h00ff, 16'h003c);
		wr(a_baud, 16'h0000);
		wr(a_irq, 16'h0001);
	endtask
	task automatic t_tx();
		logic [15:0] got;
		int n;
		got = 16'h0000;
		wr(a_cfg, 16'h0017);
		wr(a_ctl, 16'h0001);
		wr(a_dat, 16'h005a);
		#1;
		for (n = 0; n < 40 && mp_uart_if_i.line_a_to_b !== 1'b0; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 40) begin
			mismatches++;
			summarize();
		end
		repeat (8) @(posedge clk_i);
		// sample the centre of each of the nine bits, lsb first
		for (n = 0; n < 9; n++) begin
			repeat (16) @(posedge clk_i);
			#1 got[n] = mp_uart_if_i.line_a_to_b;
		end
		chk("tx frame", 16'h015a, got);
		repeat (40) @(posedge clk_i);
		rd("filter and done", a_ctl, 16'h0041, 16'h0041);
	endtask
	// 8-bit, two stops, filter off: both stops high, done only after the second
	task automatic t_tx2();
		logic [15:0] got;
		int n;
		got = 16'h0000;
		wr(a_irq, 16'h0003);
		wr(a_cfg, 16'h000b);
		wr(a_ctl, 16'h0000);
		wr(a_dat, 16'h00c3);
		#1;
		for (n = 0; n < 40 && mp_uart_if_i.line_a_to_b !== 1'b0; n++) begin
			@(posedge clk_i);
			#1;
		end
		if (n == 40) begin
			mismatches++;
			summarize();
		end
		repeat (8) @(posedge clk_i);
		// eight data bits then both stop bits, centre of each
		for (n = 0; n < 10; n++) begin
			repeat (16) @(posedge clk_i);
			#1 got[n] = mp_uart_if_i.line_a_to_b;
		end
		chk("tx two stops", 16'h03c3, got);
		rd("tx busy in stop", a_irq, 16'h0002, 16'h0000);
		repeat (16) @(posedge clk_i);
		rd("tx done", a_irq, 16'h0002, 16'h0002);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		rst_i = 1'b1;
		addr_i = 3'h0;
		wdata_i = 16'h0000;
		wr_i = 1'b0;
		rd_i = 1'b0;
		send_i = 1'b0;
		is_addr_i = 1'b0;
		data_i = 8'h00;
		nine = 1'b1;
		csz = 3'h3;
		mismatches = 0;
		tests_run = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_nine();
		t_open();
		t_eight();
		t_double();
		t_tx();
		t_tx2();
		summarize();
	end
endmodule
